// [verilog/store_narrow_and_sub_imm_exec.v]
`include "narrow_store_sub_defines.vh"

module store_narrow_and_sub_imm_exec (
  input wire i_clk,
  input wire i_rstn,
  input wire i_valid,
  input wire [15:0] i_instr,
  input wire i_cond_pass,
  input wire i_inside_cond_block,
  input wire [31:0] i_base_val,
  input wire [31:0] i_offset_val,
  input wire [31:0] i_source_val,
  input wire [3:0] i_condition_flag_word,
  output reg o_mem_write,
  output reg [31:0] o_mem_addr,
  output reg [31:0] o_mem_wdata,
  output reg [1:0] o_mem_size,
  output reg [3:0] o_mem_lanes,
  output reg o_reg_write,
  output reg [2:0] o_reg_dest,
  output reg [31:0] o_reg_wdata,
  output reg o_flag_write,
  output reg [3:0] o_condition_flag_word,
  output reg o_decoded,
  output reg [2:0] o_rd_base_sel,
  output reg [2:0] o_rd_offset_sel,
  output reg [2:0] o_rd_source_sel
);
  reg [31:0] next_mem_addr;
  reg [31:0] next_mem_wdata;
  reg [1:0] next_mem_size;
  reg [3:0] next_mem_lanes;
  wire [3:0] next_flags;
  wire store_op;
  wire store_byte_imm;
  wire store_byte_reg;
  wire store_half_imm;
  wire store_half_reg;
  wire sub_three;
  wire sub_short;
  wire store_byte_op;
  wire store_halfword_op;
  wire subtract_set_flags_op;
  wire [4:0] five_bit_offset_field;
  wire [2:0] three_bit_const_field;
  wire [7:0] eight_bit_const_field;
  wire [2:0] base_reg_field;
  wire [2:0] source_reg_field;
  wire [2:0] offset_reg_field;
  wire [2:0] shared_reg_field;
  wire [31:0] offset_amount;
  wire [31:0] sub_imm;
  wire [31:0] diff;
  wire diff_carry;
  wire diff_overflow;
  wire fire;

  // Five-bit opcode compare, shared by every short-opcode form
  function match5;
    input [15:0] instr;
    input [4:0] code;
    begin
      match5 = (instr[`OPC5_HI:`OPC5_LO] == code);
    end
  endfunction

  // Seven-bit opcode compare, shared by every long-opcode form
  function match7;
    input [15:0] instr;
    input [6:0] code;
    begin
      match7 = (instr[`OPC5_HI:`OPC7_LO] == code);
    end
  endfunction

  // Zero extension of a short field to a full word
  function [31:0] zext8;
    input [7:0] value;
    begin
      zext8 = {24'h000000, value};
    end
  endfunction

  // Operand values are read outside this block; the selects below tell the
  // register file what to fetch, a cycle after the instruction was seen.
  assign store_byte_imm = match5(i_instr, `OPC5_STORE_BYTE_IMM);
  assign store_half_imm = match5(i_instr, `OPC5_STORE_HALF_IMM);
  assign sub_short = match5(i_instr, `OPC5_SUB_SHORT);
  assign store_byte_reg = match7(i_instr, `OPC7_STORE_BYTE_REG);
  assign store_half_reg = match7(i_instr, `OPC7_STORE_HALF_REG);
  assign sub_three = match7(i_instr, `OPC7_SUB_THREE);
  assign store_byte_op = store_byte_imm | store_byte_reg;
  assign store_halfword_op = store_half_imm | store_half_reg;
  assign subtract_set_flags_op = sub_three | sub_short;

  assign five_bit_offset_field = i_instr[`FLD_FIVE_BIT_OFFSET_FIELD_HI:`FLD_FIVE_BIT_OFFSET_FIELD_LO];
  assign three_bit_const_field = i_instr[`FLD_MID_HI:`FLD_MID_LO];
  assign eight_bit_const_field = i_instr[`FLD_EIGHT_BIT_CONST_FIELD_HI:`FLD_EIGHT_BIT_CONST_FIELD_LO];
  assign offset_reg_field = i_instr[`FLD_MID_HI:`FLD_MID_LO];
  assign base_reg_field = i_instr[`FLD_BASE_HI:`FLD_BASE_LO];
  assign source_reg_field = i_instr[`FLD_SRC_HI:`FLD_SRC_LO];
  assign shared_reg_field = i_instr[`FLD_RDN_HI:`FLD_RDN_LO];

  // Register-offset forms use the offset register unshifted
  assign offset_amount = store_byte_imm ? zext8({3'h0, five_bit_offset_field}) :
                         store_half_imm ? zext8({2'h0, five_bit_offset_field, 1'b0}) :
                         i_offset_val;

  assign sub_imm = sub_three ? zext8({5'h00, three_bit_const_field}) :
                   zext8(eight_bit_const_field);
  assign store_op = store_byte_op | store_halfword_op;

  carry_adder u_carry_adder (
    .i_a(i_base_val),
    .i_b(~sub_imm),
    .i_carry_in(1'b1),
    .o_sum(diff),
    .o_carry(diff_carry),
    .o_overflow(diff_overflow)
  );

  assign fire = i_valid & i_cond_pass;

  // Store address and data formed ahead of the register stage
  always @* begin
    next_mem_addr = i_base_val + offset_amount;
    if (store_byte_op) begin
      next_mem_wdata = i_source_val & `BYTE_MASK;
      next_mem_size = `SIZE_BYTE;
      next_mem_lanes = `STORE_BYTE_OP_LANES;
    end else begin
      next_mem_wdata = i_source_val & `HALF_MASK;
      next_mem_size = `SIZE_HALF;
      next_mem_lanes = `STORE_HALFWORD_OP_LANES;
    end
  end

  // Flags straight from the adder, never from a separate subtractor
  assign next_flags = {diff[`SIGN_BIT], (diff == `WORD_ZERO),
                       diff_carry, diff_overflow};

  // Decode status and register selects, updated every cycle
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_decoded <= 1'b0;
      o_rd_base_sel <= `REG_ZERO;
      o_rd_offset_sel <= `REG_ZERO;
      o_rd_source_sel <= `REG_ZERO;
    end else begin
      o_decoded <= i_valid & (store_op | subtract_set_flags_op);
      o_rd_base_sel <= sub_short ? shared_reg_field : base_reg_field;
      o_rd_offset_sel <= offset_reg_field;
      o_rd_source_sel <= source_reg_field;
    end
  end

  // Memory side; base register never written back by stores
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_write <= 1'b0;
      o_mem_addr <= `WORD_ZERO;
      o_mem_wdata <= `WORD_ZERO;
      o_mem_size <= `SIZE_NONE;
      o_mem_lanes <= `LANES_NONE;
    end else begin
      o_mem_write <= fire & store_op;
      // Data lines hold the last store so a slow sink can read them late
      if (fire & store_op) begin
        o_mem_addr <= next_mem_addr;
        o_mem_wdata <= next_mem_wdata;
        o_mem_size <= next_mem_size;
        o_mem_lanes <= next_mem_lanes;
      end
    end
  end

  // Register write of the difference
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_write <= 1'b0;
      o_reg_dest <= `REG_ZERO;
      o_reg_wdata <= `WORD_ZERO;
    end else begin
      o_reg_write <= fire & subtract_set_flags_op;
      if (fire & subtract_set_flags_op) begin
        o_reg_dest <= sub_short ? shared_reg_field : source_reg_field;
        o_reg_wdata <= diff;
      end
    end
  end

  // Flag word: the register write above still happens inside a conditional
  // block, only the flag update is held back there
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flag_write <= 1'b0;
      o_condition_flag_word <= `FLAGS_ZERO;
    end else begin
      o_flag_write <= fire & subtract_set_flags_op & ~i_inside_cond_block;
      if (fire & subtract_set_flags_op & ~i_inside_cond_block) begin
        o_condition_flag_word <= next_flags;
      end else if (!o_flag_write) begin
        // Hold one cycle after an update so the new flags reach the core
        o_condition_flag_word <= i_condition_flag_word;
      end
    end
  end
endmodule

// [include/narrow_store_sub_defines.vh]
`ifndef NARROW_STORE_SUB_DEFINES_VH
`define NARROW_STORE_SUB_DEFINES_VH

`define OPC5_HI 15
`define OPC5_LO 11
`define OPC7_LO 9
`define OPC5_STORE_BYTE_IMM 5'h0E
`define OPC5_STORE_HALF_IMM 5'h10
`define OPC5_SUB_SHORT 5'h07
`define OPC7_STORE_BYTE_REG 7'h2A
`define OPC7_STORE_HALF_REG 7'h29
`define OPC7_SUB_THREE 7'h0F

`define FLD_FIVE_BIT_OFFSET_FIELD_HI 10
`define FLD_FIVE_BIT_OFFSET_FIELD_LO 6
`define FLD_MID_HI 8
`define FLD_MID_LO 6
`define FLD_BASE_HI 5
`define FLD_BASE_LO 3
`define FLD_SRC_HI 2
`define FLD_SRC_LO 0
`define FLD_RDN_HI 10
`define FLD_RDN_LO 8
`define FLD_EIGHT_BIT_CONST_FIELD_HI 7
`define FLD_EIGHT_BIT_CONST_FIELD_LO 0

`define SIZE_NONE 2'h0
`define LANES_NONE 4'h0
`define REG_ZERO 3'h0
`define FLAGS_ZERO 4'h0
`define SIZE_BYTE 2'h1
`define SIZE_HALF 2'h2
`define STORE_BYTE_OP_LANES 4'h1
`define STORE_HALFWORD_OP_LANES 4'h3
`define WORD_ZERO 32'h0000_0000
`define BYTE_MASK 32'h0000_00FF
`define HALF_MASK 32'h0000_FFFF
`define SIGN_BIT 31

`endif

// [verilog/carry_adder.v]
`include "narrow_store_sub_defines.vh"

module carry_adder (
  input wire [31:0] i_a,
  input wire [31:0] i_b,
  input wire i_carry_in,
  output wire [31:0] o_sum,
  output wire o_carry,
  output wire o_overflow
);
  wire [32:0] full_sum;

  assign full_sum = {1'b0, i_a} + {1'b0, i_b} + {32'h0000_0000, i_carry_in};
  assign o_sum = full_sum[31:0];
  assign o_carry = full_sum[32];
  // Signed overflow: same-sign inputs giving a sign change
  assign o_overflow = (i_a[`SIGN_BIT] == i_b[`SIGN_BIT]) &&
                      (full_sum[`SIGN_BIT] != i_a[`SIGN_BIT]);
endmodule

// [bench/narrow_store_sub_assertions.sv]
module narrow_store_sub_checker (
  input wire i_clk, i_rstn, i_valid, i_cond_pass, i_inside_cond_block,
  input wire [15:0] i_instr,
  input wire [31:0] i_base_val, i_offset_val, i_source_val,
  input wire o_mem_write, o_reg_write, o_flag_write,
  input wire [31:0] o_mem_addr, o_mem_wdata, o_reg_wdata,
  input wire [3:0] o_mem_lanes, o_condition_flag_word
);
  timeunit 1ns / 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire go = i_valid && i_cond_pass;
  wire sb = i_instr[15:11] == 5'h0E;
  wire sh = i_instr[15:11] == 5'h10;
  wire su = i_instr[15:9] == 7'h0F || i_instr[15:11] == 5'h07;
  byte_imm_addr_a: assert property (go && sb |=> o_mem_write &&
    o_mem_addr == $past(i_base_val) + $past(i_instr[10:6])) else $error("byte address");
  byte_data_a: assert property (go && (sb || i_instr[15:9] == 7'h2A) |=>
    o_mem_lanes == 4'h1 && o_mem_wdata == {24'h0, $past(i_source_val[7:0])}) else $error("byte");
  byte_reg_addr_a: assert property (go && i_instr[15:9] == 7'h2A |=>
    o_mem_addr == $past(i_base_val) + $past(i_offset_val)) else $error("byte reg address");
  half_imm_addr_a: assert property (go && sh |=>
    o_mem_addr == $past(i_base_val) + {$past(i_instr[10:6]), 1'b0}) else $error("half address");
  half_data_a: assert property (go && (sh || i_instr[15:9] == 7'h29) |=>
    o_mem_lanes == 4'h3 && o_mem_wdata == {16'h0, $past(i_source_val[15:0])}) else $error("half");
  sub_three_a: assert property (go && i_instr[15:9] == 7'h0F |=> o_reg_write &&
    o_reg_wdata == $past(i_base_val) - $past(i_instr[8:6])) else $error("difference");
  flag_gate_a: assert property (go && su |=>
    o_flag_write == !$past(i_inside_cond_block)) else $error("flag enable");
  no_effect_a: assert property (!go |=>
    !o_mem_write && !o_reg_write && !o_flag_write) else $error("effect without condition");
  flag_value_a: assert property (o_flag_write |->
    o_condition_flag_word[3:2] == {o_reg_wdata[31], o_reg_wdata == 32'h0}) else $error("flags");
endmodule

bind store_narrow_and_sub_imm_exec narrow_store_sub_checker u_narrow_store_sub_checker (.*);

// [bench/mem_sink_model.sv]
module mem_sink_model (
  input wire i_clk,
  input wire i_wr,
  output int o_count = 0
);
  timeunit 1ns / 1ps;
  // No back-pressure on the store side, so a tally of writes is all it keeps
  always @(posedge i_clk) if (i_wr) o_count <= o_count + 1;
endmodule

// [bench/tb_top.sv]
module tb_top;
  timeunit 1ns / 1ps;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_valid = 1'b0, i_cond_pass = 1'b0;
  logic i_inside_cond_block = 1'b0, em, er, ef, g, bo;
  logic [15:0] i_instr = 16'h0;
  logic [31:0] i_base_val = 32'h0, i_offset_val = 32'h0, i_source_val = 32'h0;
  logic [31:0] x = 32'hE9CA8E80, r = 32'h0, a = 32'h0, b = 32'h0, s = 32'h0, d, im;
  logic [3:0] i_condition_flag_word = 4'h0;
  logic [2:0] k;
  // Last two kinds sit one bit away from group opcodes and must be ignored
  logic [15:0] op [8] = '{16'h7000, 16'h5400, 16'h8000, 16'h5200,
    16'h1E00, 16'h3800, 16'h5600, 16'h7800};
  logic [7:0] sev = 8'h5A;
  wire o_mem_write, o_reg_write, o_flag_write, o_decoded;
  wire [31:0] o_mem_addr, o_mem_wdata, o_reg_wdata;
  wire [1:0] o_mem_size;
  wire [3:0] o_mem_lanes, o_condition_flag_word;
  wire [2:0] o_reg_dest, o_rd_base_sel, o_rd_offset_sel, o_rd_source_sel;
  int err_count = 0, compares = 0, cycles = 0, stores = 0, sink_count;
  store_narrow_and_sub_imm_exec u_store_narrow_and_sub_imm_exec (.*);
  mem_sink_model u_mem_sink_model (.i_clk(i_clk), .i_wr(o_mem_write), .o_count(sink_count));
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cycles == 5000) begin
    err_count++;
    finish_test();
  end
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    compares++;
    if (v !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (800) begin
      @(negedge i_clk);
      k = r[18:16];
      g = r[27:26] != 2'h0 && r[24:23] != 2'h0;
      bo = k < 3'h2;
      em = g && k < 3'h4;
      er = g && k[2:1] == 2'h2;
      im = k == 3'h4 ? r[8:6] : r[7:0];
      d = a - im;
      ef = er && !r[25];
      chk("mem_write", em, o_mem_write);
      chk("reg_write", er, o_reg_write);
      chk("flag_write", ef, o_flag_write);
      chk("decoded", r[27:26] != 2'h0 && k < 3'h6, o_decoded);
      chk("base_sel", k == 3'h5 ? r[10:8] : r[5:3], o_rd_base_sel);
      chk("offset_sel", r[8:6], o_rd_offset_sel);
      chk("source_sel", r[2:0], o_rd_source_sel);
      chk("flags", ef ? {d[31], d == 32'h0, a >= im, a[31] && !d[31]} : r[31:28],
        o_condition_flag_word);
      if (em) begin
        stores++;
        chk("addr", a + (k == 3'h0 ? r[10:6] : k == 3'h2 ? {r[10:6], 1'b0} : b),
          o_mem_addr);
        chk("wdata", s & (bo ? 32'h0000_00FF : 32'h0000_FFFF), o_mem_wdata);
        chk("lanes", bo ? 4'h1 : 4'h3, o_mem_lanes);
        chk("size", bo ? 32'h1 : 32'h2, o_mem_size);
      end
      if (er) begin
        chk("dest", k == 3'h4 ? r[2:0] : r[10:8], o_reg_dest);
        chk("diff", d, o_reg_wdata);
      end
      @(posedge i_clk);
      r = rnd();
      b = rnd();
      s = rnd();
      a = r[21:20] == 2'h0 ? 32'h8000_0000 : r[21:20] == 2'h1 ? {24'h0, r[7:0]} : rnd();
      k = r[18:16];
      i_instr <= op[k] | (r[15:0] & (sev[k] ? 16'h01FF : 16'h07FF));
      i_valid <= r[27:26] != 2'h0;
      i_cond_pass <= r[24:23] != 2'h0;
      i_inside_cond_block <= r[25];
      i_condition_flag_word <= r[31:28];
      i_base_val <= a;
      i_offset_val <= b;
      i_source_val <= s;
      // Idle edge after each instruction: its result is checked before the next
      @(posedge i_clk);
      i_valid <= 1'b0;
    end
    chk("sink", stores, sink_count);
    finish_test();
  end
endmodule
